// file: idst_alu.sv
// immediate-operand alu: logic, add, subtract and shift for the execute state
`timescale 1ns/1ps
module idst_alu (
  idst_alu_if.alu a // operands in, results out
);
  import idst_pkg::*;
  logic [8:0] wide;
  always_comb begin
    wide = 9'h000;
    a.result = a.acc;
    a.carry_out = a.carry_in;
    a.carry_we = 1'b0;
    a.acc_we = 1'b1;
    a.mem_op = 1'b1;
    case (a.op)
      LOAD_IMMEDIATE_OP: a.result = a.imm;
      OR_IMMEDIATE_OP: a.result = a.imm | a.acc;
      AND_IMMEDIATE_OP: a.result = a.imm & a.acc;
      XOR_IMMEDIATE_OP: a.result = a.imm ^ a.acc;
      ADD_IMMEDIATE_OP: begin
        wide = {1'b0, a.imm} + {1'b0, a.acc};
        a.result = wide[7:0];
        a.carry_out = wide[8];
        a.carry_we = 1'b1;
      end
      SUB_ACC_FROM_IMM_OP: begin
        // carry set means no borrow
        wide = {1'b0, a.imm} + {1'b0, ~a.acc} + 9'h001;
        a.result = wide[7:0];
        a.carry_out = wide[8];
        a.carry_we = 1'b1;
      end
      SUB_IMM_FROM_ACC_OP: begin
        wide = {1'b0, a.acc} + {1'b0, ~a.imm} + 9'h001;
        a.result = wide[7:0];
        a.carry_out = wide[8];
        a.carry_we = 1'b1;
      end
      SHIFT_LEFT_OP: begin
        a.result = {a.acc[6:0], 1'b0};
        a.carry_out = a.acc[7];
        a.carry_we = 1'b1;
        a.mem_op = 1'b0;
      end
      default: begin
        a.acc_we = 1'b0;
        a.mem_op = 1'b0;
      end
    endcase
  end
endmodule

// file: idst_alu_if.sv
// interface: operands and results between the state machine and the immediate alu
`timescale 1ns/1ps
interface idst_alu_if;
  logic [3:0] op;
  logic [7:0] acc;
  logic [7:0] imm;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic carry_we;
  logic acc_we;
  logic mem_op;
  modport ctl (output op, output acc, output imm, output carry_in,
               input result, input carry_out, input carry_we, input acc_we, input mem_op);
  modport alu (input op, input acc, input imm, input carry_in,
               output result, output carry_out, output carry_we, output acc_we, output mem_op);
endinterface

// file: idst_core.sv
// core state sequencer: immediate execute, dma in/out, interrupt entry and load mode
`timescale 1ns/1ps
module idst_core #(
  parameter int DATA_WIDTH = idst_pkg::DATA_W, // data bus and accumulator width
  parameter int ADDR_WIDTH = idst_pkg::ADDR_W, // memory address and pointer width
  parameter int SEL_WIDTH = idst_pkg::SEL_W // selector width
) (
  input wire logic clock, // 100 mhz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic clear_n, // clear input, low with wait_n low selects load mode
  input wire logic wait_n, // wait input
  input wire logic dma_in_req, // dma-in request
  input wire logic dma_out_req, // dma-out request
  input wire logic irq_req, // interrupt request
  input wire logic [7:0] opcode_in, // current instruction byte
  input wire logic op_valid, // opcode_in holds an instruction to execute
  input wire logic [15:0] pc_in, // address held by the current program counter register
  input wire logic [7:0] data_in, // data bus input
  output logic [7:0] data_out, // data bus output
  output logic data_oe_n, // data bus output enable, low while driving
  output logic [15:0] mem_addr, // memory address
  output logic mem_read_strobe_n, // memory read strobe
  output logic mem_write_strobe_n, // memory write strobe
  output logic first_timing_pulse, // first timing pulse of the cycle
  output logic [7:0] acc, // accumulator
  output logic carry_flag, // carry flag
  output logic pc_step, // one-cycle pulse: advance the program counter register
  output logic [15:0] r0, // dma pointer register
  output logic irq_allow, // interrupt enable
  output logic [3:0] pc_sel, // program-counter selector
  output logic [3:0] dp_sel, // data-pointer selector
  output logic [7:0] save_reg, // saved selectors, data-pointer high nibble
  output logic [4:0] state // current machine state, one-hot
);
  import idst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // the datapath is written for the documented widths only
  if (DATA_WIDTH != DATA_W || ADDR_WIDTH != ADDR_W || SEL_WIDTH != SEL_W) begin : g_width_check
    $error("idst_core serves only 8-bit data, 16-bit addresses and 4-bit selectors");
  end

  ////////////////////////////////////////////////////////////////////////////
  // immediate alu: purely combinational, its results are taken only in the execute state
  idst_alu_if alu_bus ();
  idst_alu u_alu (
    .a(alu_bus)
  );

  idst_state_t state_q;
  idst_state_t state_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic carry_q;
  logic carry_d;
  logic [15:0] r0_q;
  logic [15:0] r0_d;
  logic allow_q;
  logic allow_d;
  logic [3:0] psel_q;
  logic [3:0] psel_d;
  logic [3:0] xsel_q;
  logic [3:0] xsel_d;
  logic [7:0] save_q;
  logic [7:0] save_d;
  logic [7:0] dout_q;
  logic [7:0] dout_d;
  logic oe_n_q;
  logic oe_n_d;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic rd_n_q;
  logic rd_n_d;
  logic wr_n_q;
  logic wr_n_d;
  logic tpa_q;
  logic tpa_d;
  logic step_q;
  logic step_d;
  logic load_mode;
  logic dma_pending;
  logic idle_load;
  logic do_exec;
  logic do_dma_in;
  logic do_dma_out;
  logic do_irq;

  assign load_mode = !clear_n && !wait_n;
  assign dma_pending = dma_in_req || dma_out_req;
  // decode of the current cycle, shared by every group below
  // a pending dma request pulls the core out of load mode, otherwise load mode wins over any state
  assign idle_load = load_mode && !dma_pending;
  assign do_exec = !idle_load && (state_q == IDST_EXECUTE);
  assign do_dma_in = !idle_load && (state_q == IDST_DMA) && dma_in_req;
  assign do_dma_out = !idle_load && (state_q == IDST_DMA) && !dma_in_req && dma_out_req;
  assign do_irq = !idle_load && (state_q == IDST_IRQ);
  assign alu_bus.op = opcode_in[3:0];
  assign alu_bus.acc = acc_q;
  assign alu_bus.imm = data_in;
  assign alu_bus.carry_in = carry_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    if (idle_load) begin
      state_d = IDST_LOAD;
    end else begin
      case (state_q)
        IDST_LOAD, IDST_FETCH: begin
          // dma beats interrupt beats instruction; the load state goes to dma if a request is pending, otherwise to fetch
          if (dma_pending) begin
            state_d = IDST_DMA;
          end else if (state_q == IDST_FETCH && irq_req && allow_q) begin
            state_d = IDST_IRQ;
          end else if (state_q == IDST_FETCH && op_valid && opcode_in[7:4] == IMM_GROUP) begin
            state_d = IDST_EXECUTE;
          end else begin
            state_d = IDST_FETCH;
          end
        end
        IDST_EXECUTE: begin
          state_d = IDST_FETCH;
        end
        IDST_DMA: begin
          // back-to-back dma cycles while any request is held
          state_d = dma_pending ? IDST_DMA : IDST_FETCH;
        end
        IDST_IRQ: begin
          state_d = IDST_FETCH;
        end
        default: begin
          state_d = IDST_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IDST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and carry: written only in the execute state
  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    if (do_exec && alu_bus.acc_we) begin
      acc_d = alu_bus.result;
    end
    if (do_exec && alu_bus.carry_we) begin
      carry_d = alu_bus.carry_out;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
      carry_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma pointer: one step per served dma cycle, wrapping at the top of memory
  always_comb begin
    r0_d = r0_q;
    if (do_dma_in || do_dma_out) begin
      r0_d = r0_q + PTR_STEP;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r0_q <= PTR_RST;
    end else begin
      r0_q <= r0_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt entry: nothing here sets the allow bit again, that belongs to a later return
  always_comb begin
    allow_d = allow_q;
    psel_d = psel_q;
    xsel_d = xsel_q;
    save_d = save_q;
    if (do_irq) begin
      save_d = {xsel_q, psel_q};
      allow_d = 1'b0;
      psel_d = IRQ_PC_SEL;
      xsel_d = IRQ_DP_SEL;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      allow_q <= 1'b1;
      psel_q <= SEL_RST;
      xsel_q <= SEL_RST;
      save_q <= ACC_RST;
    end else begin
      allow_q <= allow_d;
      psel_q <= psel_d;
      xsel_q <= xsel_d;
      save_q <= save_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs: strobes and address are registered, so they lag the state by one cycle
  always_comb begin
    dout_d = dout_q;
    oe_n_d = 1'b1;
    addr_d = addr_q;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    tpa_d = 1'b1;
    step_d = 1'b0;
    if (idle_load) begin
      // idle on r0 - 1 with read asserted; the pulse stays low
      addr_d = r0_q - PTR_STEP;
      rd_n_d = 1'b0;
      tpa_d = 1'b0;
    end else if (do_exec) begin
      // operand sampled from the bus in the execute state, one cycle before the registered read strobe
      addr_d = pc_in;
      if (alu_bus.mem_op) begin
        rd_n_d = 1'b0;
        step_d = 1'b1;
      end
    end else if (state_q == IDST_DMA) begin
      addr_d = r0_q;
      if (do_dma_in) begin
        wr_n_d = 1'b0;
      end else if (do_dma_out) begin
        rd_n_d = 1'b0;
      end
    end else if (state_q == IDST_LOAD) begin
      // leaving load mode: the pulse stays suppressed for this last cycle
      tpa_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= ACC_RST;
      oe_n_q <= 1'b1;
      addr_q <= PTR_RST;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      tpa_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      addr_q <= addr_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      tpa_q <= tpa_d;
      step_q <= step_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the core never drives the bus here: memory or the i/o device does
  assign data_out = dout_q;
  assign data_oe_n = oe_n_q;
  assign mem_addr = addr_q;
  assign mem_read_strobe_n = rd_n_q;
  assign mem_write_strobe_n = wr_n_q;
  assign first_timing_pulse = tpa_q;
  assign acc = acc_q;
  assign carry_flag = carry_q;
  assign pc_step = step_q;
  assign r0 = r0_q;
  assign irq_allow = allow_q;
  assign pc_sel = psel_q;
  assign dp_sel = xsel_q;
  assign save_reg = save_q;
  assign state = state_q;
endmodule

// file: idst_core_monitor.sv
// checker: port properties of the immediate, dma, interrupt and load states
`timescale 1ns/1ps
module idst_core_monitor (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic clear_n, // clear
  input wire logic wait_n, // wait
  input wire logic dma_in_req, // dma-in request
  input wire logic dma_out_req, // dma-out request
  input wire logic irq_req, // interrupt request
  input wire logic [7:0] opcode_in, // opcode
  input wire logic op_valid, // opcode valid
  input wire logic [15:0] pc_in, // program counter
  input wire logic [7:0] data_in, // data bus in
  input wire logic [15:0] mem_addr, // address
  input wire logic mem_read_strobe_n, // read strobe
  input wire logic mem_write_strobe_n, // write strobe
  input wire logic first_timing_pulse, // timing pulse
  input wire logic [7:0] acc, // accumulator
  input wire logic carry_flag, // carry
  input wire logic pc_step, // counter step
  input wire logic [15:0] r0, // dma pointer
  input wire logic irq_allow, // interrupt enable
  input wire logic [3:0] pc_sel, // pc selector
  input wire logic [3:0] dp_sel, // dp selector
  input wire logic [4:0] state // state
);
  import idst_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic run;
  assign run = clear_n && wait_n && !dma_in_req && !dma_out_req && !irq_req;
  sequence ex_s(logic [3:0] n);
    state == IDST_FETCH && run && op_valid && opcode_in == {IMM_GROUP, n} ##1 state == IDST_EXECUTE;
  endsequence
  ldi_load_a: assert property (ex_s(LOAD_IMMEDIATE_OP) |=> acc == $past(data_in) &&
    !mem_read_strobe_n && pc_step && mem_addr == $past(pc_in)) else $error("load immediate wrong");
  add_carry_a: assert property (ex_s(ADD_IMMEDIATE_OP) |=>
    {carry_flag, acc} == {1'b0, $past(acc)} + {1'b0, $past(data_in)}) else $error("add wrong");
  sub_borrow_a: assert property (ex_s(SUB_IMM_FROM_ACC_OP) |=>
    {carry_flag, acc} == {1'b1, $past(acc)} - {1'b0, $past(data_in)}) else $error("subtract wrong");
  shift_left_a: assert property (ex_s(SHIFT_LEFT_OP) |=> carry_flag == $past(acc[7]) &&
    acc == {$past(acc[6:0]), 1'b0} && mem_read_strobe_n && mem_write_strobe_n) else $error("shift wrong");
  dma_in_a: assert property (state == IDST_DMA && dma_in_req |=> !mem_write_strobe_n &&
    mem_read_strobe_n && mem_addr == $past(r0) && r0 == $past(r0) + PTR_STEP) else $error("dma in wrong");
  dma_out_a: assert property (state == IDST_DMA && !dma_in_req && dma_out_req |=>
    !mem_read_strobe_n && mem_addr == $past(r0) && r0 == $past(r0) + PTR_STEP) else $error("dma out wrong");
  irq_entry_a: assert property (state == IDST_FETCH && irq_req && irq_allow && clear_n && wait_n &&
    !dma_in_req && !dma_out_req |=> ##[0:2] (pc_sel == IRQ_PC_SEL && dp_sel == IRQ_DP_SEL && !irq_allow))
    else $error("interrupt entry wrong");
  load_mode_a: assert property (state == IDST_FETCH && !clear_n && !wait_n && !dma_in_req &&
    !dma_out_req && !irq_req |=> ##[0:1] (state == IDST_LOAD && !mem_read_strobe_n &&
    !first_timing_pulse && mem_addr == r0 - PTR_STEP)) else $error("load mode wrong");
endmodule
bind idst_core idst_core_monitor i_idst_core_monitor (.*);

// file: idst_core_tb.sv
// testbench: immediate ops, dma cycles, interrupt entry and load mode
`timescale 1ns/1ps
module idst_core_tb;
  import idst_pkg::*;
  logic clock = 0, rst_n = 0, clear_n = 1, wait_n = 1, op_valid = 0, ec = 0;
  logic dma_in_req = 0, dma_out_req = 0, irq_req = 0;
  logic [7:0] opcode_in = 8'h00, data_in, data_out, acc, save_reg, io_byte = 8'h3C, em = ACC_RST;
  logic [15:0] pc_in = 16'h0010, mem_addr, r0, r;
  logic data_oe_n, mem_read_strobe_n, mem_write_strobe_n, first_timing_pulse, carry_flag, pc_step, irq_allow;
  logic [3:0] pc_sel, dp_sel;
  logic [4:0] state;
  int err_count = 0, n_tests = 0;
  idst_core i_idst_core (.*);
  idst_mem_model i_idst_mem_model (.*);
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_st(input idst_state_t s);
    for (int i = 0; i < 20 && state !== s; i++) @(posedge clock) #1;
    if (state !== s) chk(16'(state), 16'(s));
  endtask
  task automatic t_imm(input logic [3:0] op);
    logic [8:0] s;
    logic [7:0] m;
    m = 8'(pc_in + 16'h1) ^ 8'h5A;
    @(posedge clock);
    pc_in <= pc_in + 16'h1;
    opcode_in <= {IMM_GROUP, op};
    op_valid <= 1;
    wait_st(IDST_EXECUTE);
    @(posedge clock);
    op_valid <= 0;
    case (op)
      LOAD_IMMEDIATE_OP: s = {ec, m};
      OR_IMMEDIATE_OP: s = {ec, m | em};
      AND_IMMEDIATE_OP: s = {ec, m & em};
      XOR_IMMEDIATE_OP: s = {ec, m ^ em};
      ADD_IMMEDIATE_OP: s = {1'b0, m} + {1'b0, em};
      SUB_ACC_FROM_IMM_OP: s = {1'b1, m} - {1'b0, em};
      SUB_IMM_FROM_ACC_OP: s = {1'b1, em} - {1'b0, m};
      default: s = {em, 1'b0};
    endcase
    #1;
    chk({7'h00, carry_flag, acc}, {7'h00, s});
    chk({13'h0000, mem_read_strobe_n, mem_write_strobe_n, pc_step},
        {13'h0000, op == SHIFT_LEFT_OP, 1'b1, op != SHIFT_LEFT_OP});
    chk({7'h00, data_oe_n, data_out}, {7'h00, 1'b1, ACC_RST});
    em = s[7:0];
    ec = s[8];
  endtask
  task automatic t_dma;
    r = r0;
    @(posedge clock);
    dma_in_req <= 1;
    dma_out_req <= 1;
    wait_st(IDST_DMA);
    @(posedge clock);
    dma_in_req <= 0;
    #1;
    chk({15'h0000, mem_write_strobe_n}, 16'h0000);
    chk(mem_addr, r);
    @(posedge clock);
    dma_out_req <= 0;
    #1;
    chk({15'h0000, mem_read_strobe_n}, 16'h0000);
    chk(mem_addr, r + 16'h1);
    chk(r0, r + 16'h2);
    wait_st(IDST_FETCH);
    chk(16'(i_idst_mem_model.mem[r[7:0]]), 16'(io_byte));
  endtask
  task automatic t_irq;
    @(posedge clock);
    irq_req <= 1;
    wait_st(IDST_IRQ);
    @(posedge clock);
    irq_req <= 0;
    wait_st(IDST_FETCH);
    chk({pc_sel, dp_sel, save_reg}, {IRQ_PC_SEL, IRQ_DP_SEL, SEL_RST, SEL_RST});
    chk(16'(irq_allow), 16'h0000);
  endtask
  task automatic t_load;
    @(posedge clock);
    clear_n <= 0;
    wait_n <= 0;
    wait_st(IDST_LOAD);
    @(posedge clock) #1;
    chk({14'h0000, first_timing_pulse, mem_read_strobe_n}, 16'h0000);
    chk(mem_addr, r0 - 16'h1);
    r = r0;
    @(posedge clock);
    dma_in_req <= 1;
    wait_st(IDST_DMA);
    @(posedge clock);
    dma_in_req <= 0;
    #1;
    chk(r0, r + 16'h1);
    @(posedge clock);
    clear_n <= 1;
    wait_n <= 1;
    wait_st(IDST_FETCH);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1;
    for (int k = 0; k < 16; k++) t_imm(4'(8 + k % 8));
    t_dma();
    t_irq();
    t_load();
    test_done();
  end
endmodule

// file: idst_mem_model.sv
// partner model: memory and i/o device on the shared data bus
`timescale 1ns/1ps
module idst_mem_model (
  input wire logic clock, // clock
  input wire logic [4:0] state, // core state, one-hot
  input wire logic [15:0] pc_in, // program counter address
  input wire logic [15:0] mem_addr, // memory address
  input wire logic mem_read_strobe_n, // read strobe
  input wire logic mem_write_strobe_n, // write strobe
  input wire logic [7:0] io_byte, // byte the i/o device offers
  output logic [7:0] data_in // bus as seen by the core
);
  import idst_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] last_q;
  // arbitrary fill so every immediate differs from its neighbours
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always_comb begin
    if (!mem_write_strobe_n) data_in = io_byte;
    else if (state == IDST_EXECUTE) data_in = mem[pc_in[7:0]];
    else if (!mem_read_strobe_n) data_in = mem[mem_addr[7:0]];
    else if (state == IDST_DMA) data_in = io_byte;
    else data_in = ~last_q; // released bus must not look valid
  end
  always @(posedge clock) begin
    last_q <= data_in;
    if (!mem_write_strobe_n) mem[mem_addr[7:0]] <= data_in;
  end
endmodule

// file: idst_pkg.sv
// package: opcodes, states and reset values for the immediate/dma/interrupt state block
package idst_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int SEL_W = 4;
  // immediate group: upper opcode nibble 4'hF, low nibble selects
  localparam logic [3:0] IMM_GROUP = 4'hF;
  localparam logic [3:0] LOAD_IMMEDIATE_OP = 4'h8;
  localparam logic [3:0] OR_IMMEDIATE_OP = 4'h9;
  localparam logic [3:0] AND_IMMEDIATE_OP = 4'hA;
  localparam logic [3:0] XOR_IMMEDIATE_OP = 4'hB;
  localparam logic [3:0] ADD_IMMEDIATE_OP = 4'hC;
  localparam logic [3:0] SUB_ACC_FROM_IMM_OP = 4'hD;
  localparam logic [3:0] SHIFT_LEFT_OP = 4'hE;
  localparam logic [3:0] SUB_IMM_FROM_ACC_OP = 4'hF;
  // selector values loaded on interrupt entry
  localparam logic [3:0] IRQ_PC_SEL = 4'h1;
  localparam logic [3:0] IRQ_DP_SEL = 4'h2;
  // reset values and pointer step
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  typedef enum logic [4:0] {
    IDST_FETCH   = 5'b0_0001,
    IDST_EXECUTE = 5'b0_0010,
    IDST_DMA     = 5'b0_0100,
    IDST_IRQ     = 5'b0_1000,
    IDST_LOAD    = 5'b1_0000
  } idst_state_t;
endpackage
